// File: hw/cswk_restart_ctrl.sv
// Overview of operation
// R1: normal restart, off codes unchanged, error clear
// R2: normal restart, 001/010/011 become 001
// R3: normal restart, selective codes become 101, error set
// R4: other-source sleep restart leaves wake flags clear
// R5: pattern wake in plain mode sets wake, pattern
// R6: valid frame in sleep gives 101, frame flag
// R7: error overflow sets config error, count 100000
// R8: failed check acts plain; pattern sets error too
// R9: frame within silence leaves pattern flag clear
// R10: overflow without pattern leaves pattern clear
// R11: fail-safe forces wake-capable, selective wake off
// R12: wake restarts from sleep or fail-safe, interrupts in normal
// R13: any bus wake sets wake flag and details
// R14: quanta per bit from config and clock select
// R15: sample point from sample config
// R16: receiver select bit picks frame detector input
// R17: id, mask, data registers decide wake frame
// R18: host switches off, enables measure, drives pulse
// R19: count pulse, readable in high and low
// R20: trim writable only when unlocked and measuring
// R21: three-bit mode field encoding
// R22: config error zero means selective wake healthy
// R23: mode field reads back the rewritten code
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cswk_restart_ctrl
  import cswk_pkg::*;
#(
  parameter int CW = 16
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [CSWK_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // system mode events, one-cycle pulses
  input wire logic enterSleep,
  input wire logic enterRestart,
  input wire logic enterFailSafe,
  input wire logic enterNormal,
  input wire logic otherWake,
  // frame decoder events
  input wire logic patternSeen,
  input wire logic frameDone,
  input wire logic [10:0] frameId,
  input wire logic [63:0] frameData,
  input wire logic errOverflow,
  input wire logic silenceExpired,
  input wire logic configCheckOk,
  // receivers and bus transmit input
  input wire logic rxMain,
  input wire logic rxWake,
  input wire logic bus_transmit_input,
  // outputs
  output logic decoderRx,
  output logic [7:0] decoderQuanta,
  output logic [5:0] decoderSample,
  output logic [1:0] decoderClkSel,
  output logic transceiverOn,
  output logic selectiveActive,
  output logic restartReq,
  output logic wakeIrq
);
  cswk_state_t state, next_state;
  logic [2:0] modeSel, next_modeSel;
  logic swk_config_error, next_swk_config_error;
  logic bus_wake_flag, next_bus_wake_flag;
  logic patFlag, next_patFlag;
  logic frameFlag, next_frameFlag;
  logic [5:0] frame_error_count, next_frame_error_count;
  logic [7:0] bit_quanta_config, next_bit_quanta_config;
  logic [5:0] sample_point_config, next_sample_point_config;
  logic [1:0] recovery_clock_config, next_recovery_clock_config;
  logic [7:0] recovery_control, next_recovery_control;
  logic osc_measure_enable, next_osc_measure_enable;
  logic wake_receiver_select, next_wake_receiver_select;
  logic [1:0] trimUnlock, next_trimUnlock;
  logic [7:0] osc_trim_config, next_osc_trim_config;
  logic [7:0] osc_option_config, next_osc_option_config;
  logic frameSeenInSilence, next_frameSeenInSilence;
  logic [7:0] next_regRdData;
  logic next_decoderRx, next_transceiverOn, next_selectiveActive;
  logic next_restartReq, next_wakeIrq;
  logic [CW-1:0] pulseCount;
  logic [7:0] cfgRd;
  logic [127:0] cfgAll;
  logic cfgWr;
  logic [3:0] cfgWrAddr;
  logic frameMatch;
  logic swkArmed;
  logic plainArmed;

  assign cfgWr = regWr && regAddr >= ADDR_ID0;
  assign cfgWrAddr = 4'(regAddr - ADDR_ID0);

  cswk_cfg_mem #(.DEPTH(16), .AW(4)) u_cfg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(cfgWr),
    .wrAddr(cfgWrAddr),
    .wrData(regWrData),
    .rdAddr(4'(regAddr - ADDR_ID0)),
    .rdData(cfgRd),
    .allData(cfgAll)
  );

  // counts only while the transceiver is off, R18
  cswk_osc_meter #(.CW(CW)) u_osc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .measureEn(osc_measure_enable && !transceiverOn),
    .txPulse(bus_transmit_input),
    .pulseCount(pulseCount) // R19
  );

  // id/mask in bytes 0..7, data in bytes 8..15
  always_comb
  begin
    logic [31:0] idCfg;
    logic [31:0] maskCfg;
    logic [63:0] dataCfg;
    idCfg = cfgAll[31:0];
    maskCfg = cfgAll[63:32];
    dataCfg = cfgAll[127:64];
    // mask bit 1 means don't care
    frameMatch = (((idCfg[10:0] ^ frameId) & ~maskCfg[10:0]) == 11'h000)
      && (dataCfg == frameData); // R17
  end

  // selective wake needs a clean check
  assign swkArmed = modeSel[2] && modeSel[0] && !swk_config_error
    && state == CSWK_SLEEP; // R22
  assign plainArmed = state == CSWK_SLEEP && modeSel != MODE_OFF
    && modeSel != MODE_OFF2 && !swkArmed; // R8

  always_comb
  begin
    next_state = state;
    next_modeSel = modeSel;
    next_swk_config_error = swk_config_error;
    next_bus_wake_flag = bus_wake_flag;
    next_patFlag = patFlag;
    next_frameFlag = frameFlag;
    next_frame_error_count = frame_error_count;
    next_frameSeenInSilence = frameSeenInSilence;
    next_restartReq = 1'b0;
    next_wakeIrq = 1'b0;
    next_bit_quanta_config = bit_quanta_config;
    next_sample_point_config = sample_point_config;
    next_recovery_clock_config = recovery_clock_config;
    next_recovery_control = recovery_control;
    next_osc_measure_enable = osc_measure_enable;
    next_wake_receiver_select = wake_receiver_select;
    next_trimUnlock = trimUnlock;
    next_osc_trim_config = osc_trim_config;
    next_osc_option_config = osc_option_config;

    // host writes; hardware updates below win over clears
    if (regWr)
    begin
      unique case (regAddr)
        ADDR_MODE:
        begin
          next_modeSel = regWrData[2:0]; // R21
          if (regWrData[3])
            next_swk_config_error = 1'b0;
        end
        ADDR_STATUS:
        begin
          if (regWrData[ST_WAKE]) next_bus_wake_flag = 1'b0;
          if (regWrData[ST_PAT]) next_patFlag = 1'b0;
          if (regWrData[ST_FRAME]) next_frameFlag = 1'b0;
          if (regWrData[ST_CFGERR]) next_swk_config_error = 1'b0;
        end
        ADDR_QUANTA: next_bit_quanta_config = regWrData;
        ADDR_SAMPLE: next_sample_point_config = regWrData[5:0];
        ADDR_RECCLK: next_recovery_clock_config = regWrData[1:0];
        ADDR_RECCTL: next_recovery_control = regWrData;
        ADDR_OSCCTL:
        begin
          next_osc_measure_enable = regWrData[0];
          next_wake_receiver_select = regWrData[1];
          next_trimUnlock = regWrData[3:2]; // R20
        end
        ADDR_TRIM:
          if (trimUnlock == TRIM_UNLOCK && osc_measure_enable) // R20
            next_osc_trim_config = regWrData;
        ADDR_OPTION:
          if (trimUnlock == TRIM_UNLOCK && osc_measure_enable) // R20
            next_osc_option_config = regWrData;
        default: ;
      endcase
    end

    unique case (state)
      CSWK_NORMAL:
      begin
        if (enterFailSafe)
        begin
          next_state = CSWK_FAILSAFE;
          next_modeSel = MODE_WAKE; // R11
        end
        else if (enterRestart)
        begin
          next_state = CSWK_RESTART;
          unique case (modeSel)
            MODE_OFF, MODE_OFF2: ; // R1
            MODE_WAKE, MODE_RXONLY, MODE_NORMAL:
              next_modeSel = MODE_WAKE; // R2
            default:
            begin
              next_modeSel = MODE_SWK; // R3
              next_swk_config_error = 1'b1; // R3
            end
          endcase
        end
        else if (enterSleep)
        begin
          next_state = CSWK_SLEEP;
          next_frame_error_count = '0;
          next_frameSeenInSilence = 1'b0;
          if (modeSel == MODE_RXONLY || modeSel == MODE_NORMAL)
            next_modeSel = MODE_WAKE;
          else if (modeSel[2] && modeSel != MODE_OFF2)
          begin
            next_modeSel = MODE_SWK;
            if (!configCheckOk)
              next_swk_config_error = 1'b1; // R8
          end
        end
        else if (patternSeen && modeSel != MODE_OFF && modeSel != MODE_OFF2)
        begin
          next_wakeIrq = 1'b1; // R12
          next_bus_wake_flag = 1'b1; // R13
          next_patFlag = 1'b1;
        end
      end
      CSWK_SLEEP:
      begin
        if (silenceExpired)
          next_frameSeenInSilence = 1'b0;
        if (swkArmed && frameDone && frameMatch)
        begin
          next_state = CSWK_RESTART;
          next_restartReq = 1'b1; // R12
          next_bus_wake_flag = 1'b1; // R6
          next_frameFlag = 1'b1; // R6
          next_swk_config_error = 1'b0; // R6
          if (!frameSeenInSilence)
            next_patFlag = 1'b1; // R9
        end
        else if (swkArmed && errOverflow)
        begin
          next_state = CSWK_RESTART;
          next_restartReq = 1'b1;
          next_bus_wake_flag = 1'b1; // R7
          next_swk_config_error = 1'b1; // R7
          next_frame_error_count = ECNT_OVERFLOW; // R7
          next_frameFlag = 1'b0; // R10
        end
        else if (plainArmed && patternSeen)
        begin
          next_state = CSWK_RESTART;
          next_restartReq = 1'b1;
          next_bus_wake_flag = 1'b1; // R5
          next_patFlag = 1'b1; // R5
          next_frameFlag = 1'b0; // R5
          next_frame_error_count = '0; // R8
        end
        else if (otherWake)
        begin
          // flags untouched, mode kept
          next_state = CSWK_RESTART; // R4
          next_restartReq = 1'b1; // R4
        end
        if (swkArmed && frameDone)
          next_frameSeenInSilence = 1'b1;
      end
      CSWK_RESTART:
      begin
        if (enterFailSafe)
        begin
          next_state = CSWK_FAILSAFE;
          next_modeSel = MODE_WAKE; // R11
        end
        else if (enterNormal)
          next_state = CSWK_NORMAL;
      end
      CSWK_FAILSAFE:
      begin
        next_modeSel = MODE_WAKE; // R11
        if (enterRestart)
          next_state = CSWK_RESTART;
        if (patternSeen)
        begin
          next_bus_wake_flag = 1'b1; // R13
          next_patFlag = 1'b1;
          next_restartReq = 1'b1;
        end
      end
    endcase
  end

  always_comb
  begin
    next_transceiverOn = modeSel != MODE_OFF && modeSel != MODE_OFF2; // R1
    next_selectiveActive = swkArmed;
    next_decoderRx = wake_receiver_select ? rxWake : rxMain; // R16
    next_regRdData = 8'h00;
    if (regRd)
    begin
      unique case (regAddr)
        ADDR_MODE: next_regRdData = {5'h00, modeSel}; // R23
        ADDR_STATUS: next_regRdData = {4'h0, swk_config_error, frameFlag,
          patFlag, bus_wake_flag};
        ADDR_QUANTA: next_regRdData = bit_quanta_config;
        ADDR_SAMPLE: next_regRdData = {2'h0, sample_point_config};
        ADDR_RECCLK: next_regRdData = {6'h00, recovery_clock_config};
        ADDR_RECCTL: next_regRdData = recovery_control;
        ADDR_OSCCTL: next_regRdData = {4'h0, trimUnlock,
          wake_receiver_select, osc_measure_enable};
        ADDR_CNTHI: next_regRdData = pulseCount[15:8]; // R19
        ADDR_CNTLO: next_regRdData = pulseCount[7:0]; // R19
        ADDR_TRIM: next_regRdData = osc_trim_config;
        ADDR_OPTION: next_regRdData = osc_option_config;
        ADDR_ECNT: next_regRdData = {2'h0, frame_error_count}; // R13
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= CSWK_NORMAL;
      modeSel <= MODE_OFF;
      swk_config_error <= 1'b0;
      bus_wake_flag <= 1'b0;
      patFlag <= 1'b0;
      frameFlag <= 1'b0;
      frame_error_count <= '0;
      frameSeenInSilence <= 1'b0;
      bit_quanta_config <= QUANTA_RESET;
      sample_point_config <= SAMPLE_RESET;
      recovery_clock_config <= 2'h0;
      recovery_control <= 8'h00;
      osc_measure_enable <= 1'b0;
      wake_receiver_select <= 1'b0;
      trimUnlock <= 2'h0;
      osc_trim_config <= 8'h00;
      osc_option_config <= 8'h00;
      regRdData <= 8'h00;
      decoderRx <= 1'b1;
      decoderQuanta <= QUANTA_RESET;
      decoderSample <= SAMPLE_RESET;
      decoderClkSel <= 2'h0;
      transceiverOn <= 1'b0;
      selectiveActive <= 1'b0;
      restartReq <= 1'b0;
      wakeIrq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      modeSel <= next_modeSel;
      swk_config_error <= next_swk_config_error;
      bus_wake_flag <= next_bus_wake_flag;
      patFlag <= next_patFlag;
      frameFlag <= next_frameFlag;
      frame_error_count <= next_frame_error_count;
      frameSeenInSilence <= next_frameSeenInSilence;
      bit_quanta_config <= next_bit_quanta_config;
      sample_point_config <= next_sample_point_config;
      recovery_clock_config <= next_recovery_clock_config;
      recovery_control <= next_recovery_control;
      osc_measure_enable <= next_osc_measure_enable;
      wake_receiver_select <= next_wake_receiver_select;
      trimUnlock <= next_trimUnlock;
      osc_trim_config <= next_osc_trim_config;
      osc_option_config <= next_osc_option_config;
      regRdData <= next_regRdData;
      decoderRx <= next_decoderRx;
      decoderQuanta <= bit_quanta_config; // R14
      decoderSample <= sample_point_config; // R15
      decoderClkSel <= recovery_clock_config; // R14
      transceiverOn <= next_transceiverOn;
      selectiveActive <= next_selectiveActive;
      restartReq <= next_restartReq;
      wakeIrq <= next_wakeIrq;
    end
  end
endmodule : cswk_restart_ctrl

// File: hw/cswk_pkg.sv
package cswk_pkg;
  localparam int CSWK_AW = 5;
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h01;
  localparam logic [4:0] ADDR_QUANTA = 5'h02;
  localparam logic [4:0] ADDR_SAMPLE = 5'h03;
  localparam logic [4:0] ADDR_RECCLK = 5'h04;
  localparam logic [4:0] ADDR_RECCTL = 5'h05;
  localparam logic [4:0] ADDR_OSCCTL = 5'h06;
  localparam logic [4:0] ADDR_CNTHI = 5'h07;
  localparam logic [4:0] ADDR_CNTLO = 5'h08;
  localparam logic [4:0] ADDR_TRIM = 5'h09;
  localparam logic [4:0] ADDR_OPTION = 5'h0a;
  localparam logic [4:0] ADDR_ECNT = 5'h0b;
  localparam logic [4:0] ADDR_ID0 = 5'h10;
  localparam logic [4:0] ADDR_MASK0 = 5'h14;
  localparam logic [4:0] ADDR_DATA0 = 5'h18;
  localparam int ID_REGS = 4;
  localparam int DATA_REGS = 8;

  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_WAKE = 3'h1;
  localparam logic [2:0] MODE_RXONLY = 3'h2;
  localparam logic [2:0] MODE_NORMAL = 3'h3;
  localparam logic [2:0] MODE_OFF2 = 3'h4;
  localparam logic [2:0] MODE_SWK = 3'h5;
  localparam logic [2:0] MODE_SWKRX = 3'h6;
  localparam logic [2:0] MODE_SWKNORM = 3'h7;

  localparam logic [5:0] ECNT_OVERFLOW = 6'h20;
  localparam logic [1:0] TRIM_UNLOCK = 2'h3;
  localparam logic [5:0] SAMPLE_RESET = 6'h33;
  localparam logic [7:0] QUANTA_RESET = 8'h00;

  // status bit positions
  localparam int ST_WAKE = 0;
  localparam int ST_PAT = 1;
  localparam int ST_FRAME = 2;
  localparam int ST_CFGERR = 3;
  localparam int ST_ECNT = 8;

  typedef enum logic [1:0] {
    CSWK_NORMAL = 2'b00,
    CSWK_SLEEP = 2'b01,
    CSWK_RESTART = 2'b10,
    CSWK_FAILSAFE = 2'b11
  } cswk_state_t;
endpackage : cswk_pkg

// File: hw/cswk_cfg_mem.sv
`timescale 1ns/1ps
module cswk_cfg_mem
  import cswk_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // registered read port
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData,
  // flat view for the matcher
  output logic [DEPTH*8-1:0] allData
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_rdData;

  always_comb
  begin
    next_rdData = mem[rdAddr];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdData <= 8'h00;
    else
      rdData <= next_rdData;
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_ent
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
          mem[i] <= 8'h00;
        else if (wrEn && wrAddr == AW'(i))
          mem[i] <= wrData;
      end
      assign allData[i*8 +: 8] = mem[i];
    end
  endgenerate
endmodule : cswk_cfg_mem

// File: hw/cswk_osc_meter.sv
`timescale 1ns/1ps
module cswk_osc_meter
  import cswk_pkg::*;
#(
  parameter int CW = 16
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic measureEn,
  input wire logic txPulse,
  // result
  output logic [CW-1:0] pulseCount
);
  logic [CW-1:0] run;
  logic [CW-1:0] next_run;
  logic [CW-1:0] next_pulseCount;
  logic txLast;

  always_comb
  begin
    next_run = run;
    next_pulseCount = pulseCount;
    if (!measureEn)
      next_run = '0;
    else if (txPulse && !txLast)
      next_run = CW'(1);
    else if (txPulse && run != '1)
      next_run = run + CW'(1);
    // latch on falling edge so the host reads a stable length
    if (measureEn && !txPulse && txLast)
      next_pulseCount = run;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      run <= '0;
      pulseCount <= '0;
      txLast <= 1'b0;
    end
    else
    begin
      run <= next_run;
      pulseCount <= next_pulseCount;
      txLast <= txPulse;
    end
  end
endmodule : cswk_osc_meter

// File: test/cswk_restart_ctrl_assertions.sv
`timescale 1ns/1ps
module cswk_restart_ctrl_checker
  import cswk_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [CSWK_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // events and receivers
  input wire logic enterFailSafe,
  input wire logic otherWake,
  input wire logic patternSeen,
  input wire logic frameDone,
  input wire logic errOverflow,
  input wire logic rxMain,
  input wire logic rxWake,
  // outputs
  input wire logic decoderRx,
  input wire logic [7:0] decoderQuanta,
  input wire logic [5:0] decoderSample,
  input wire logic [1:0] decoderClkSel,
  input wire logic transceiverOn,
  input wire logic selectiveActive,
  input wire logic restartReq,
  input wire logic wakeIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic busEv;
  assign busEv = patternSeen | frameDone | errOverflow | otherWake;
  // a bus event must lie at most three edges back
  sequence bus_cause;
    $past(busEv) || $past(busEv, 2) || $past(busEv, 3);
  endsequence
  sequence fs_settled;
    ##3 transceiverOn && !selectiveActive;
  endsequence
  reset_values_a: assert property ($rose(rst_n) |->
    decoderSample == SAMPLE_RESET && decoderRx && !restartReq)
    else $error("outputs wrong after reset");
  quanta_copy_a: assert property (regWr && regAddr == ADDR_QUANTA |->
    ##2 decoderQuanta == $past(regWrData, 2)) else $error("quanta copy");
  sample_copy_a: assert property (regWr && regAddr == ADDR_SAMPLE |->
    ##2 decoderSample == $past(regWrData[5:0], 2)) else $error("sample copy");
  clock_select_a: assert property (regWr && regAddr == ADDR_RECCLK |->
    ##2 decoderClkSel == $past(regWrData[1:0], 2)) else $error("clock sel");
  rx_agree_a: assert property (rxMain == rxWake |=>
    decoderRx == $past(rxWake)) else $error("receiver path");
  read_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  config_hidden_a: assert property (regRd && regAddr >= ADDR_ID0 |=>
    regRdData == 8'h00) else $error("wake config readable");
  restart_cause_a: assert property (restartReq |-> bus_cause)
    else $error("restart without bus event");
  irq_pulse_a: assert property (wakeIrq |-> bus_cause ##1 !wakeIrq)
    else $error("interrupt without cause or too long");
  failsafe_arm_a: assert property (enterFailSafe |-> fs_settled)
    else $error("fail-safe not wake-capable");
endmodule : cswk_restart_ctrl_checker

bind cswk_restart_ctrl cswk_restart_ctrl_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .enterFailSafe(enterFailSafe),
  .otherWake(otherWake),
  .patternSeen(patternSeen), .frameDone(frameDone),
  .errOverflow(errOverflow), .rxMain(rxMain), .rxWake(rxWake),
  .decoderRx(decoderRx), .decoderQuanta(decoderQuanta),
  .decoderSample(decoderSample), .decoderClkSel(decoderClkSel),
  .transceiverOn(transceiverOn), .selectiveActive(selectiveActive),
  .restartReq(restartReq), .wakeIrq(wakeIrq));

// File: test/cswk_bus_node.sv
`timescale 1ns/1ps
module cswk_bus_node
(
  // clock and command
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [10:0] sendId,
  input wire logic [8:0] len,
  // decoder events and host transmit line
  output logic patternSeen = 1'b0,
  output logic frameDone = 1'b0,
  output logic [10:0] frameId = 11'h000,
  output logic [63:0] frameData = 64'h0,
  output logic errOverflow = 1'b0,
  output logic silenceExpired = 1'b0,
  output logic busTx = 1'b0
);
  logic [8:0] cnt = 9'h000;
  always @(posedge clk_sys)
  begin
    patternSeen <= go && kind == 3'h0;
    frameDone <= go && kind == 3'h1;
    errOverflow <= go && kind == 3'h2;
    silenceExpired <= go && kind == 3'h3;
    // id and data are junk outside the frame slot
    frameId <= (go && kind == 3'h1) ? sendId : ~frameId;
    frameData <= (go && kind == 3'h1) ? {8{8'h5a}} : ~frameData;
    if (go && kind == 3'h4)
    begin
      busTx <= 1'b1;
      cnt <= len;
    end
    else if (cnt > 9'h001)
      cnt <= cnt - 9'h001;
    else if (cnt == 9'h001)
    begin
      busTx <= 1'b0;
      cnt <= 9'h000;
    end
  end
endmodule : cswk_bus_node

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench
  import cswk_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [4:0] ev = 5'h00;
  logic configCheckOk = 1'b1, rxMain = 1'b1, rxWake = 1'b1, go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [10:0] sendId = 11'h000, frameId;
  logic [8:0] len = 9'h000;
  logic [63:0] frameData;
  logic [7:0] regRdData, decoderQuanta;
  logic [5:0] decoderSample;
  logic [1:0] decoderClkSel;
  logic patternSeen, frameDone, errOverflow, silenceExpired, busTx;
  logic decoderRx, transceiverOn, selectiveActive, restartReq, wakeIrq;
  int fail_count = 0, checks = 0, cycles = 0, nRestart = 0, nIrq = 0;

  cswk_restart_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .enterSleep(ev[0]),
    .enterRestart(ev[1]), .enterFailSafe(ev[2]), .enterNormal(ev[3]),
    .otherWake(ev[4]), .patternSeen(patternSeen), .frameDone(frameDone),
    .frameId(frameId), .frameData(frameData), .errOverflow(errOverflow),
    .silenceExpired(silenceExpired), .configCheckOk(configCheckOk),
    .rxMain(rxMain), .rxWake(rxWake), .bus_transmit_input(busTx),
    .decoderRx(decoderRx), .decoderQuanta(decoderQuanta),
    .decoderSample(decoderSample), .decoderClkSel(decoderClkSel),
    .transceiverOn(transceiverOn), .selectiveActive(selectiveActive),
    .restartReq(restartReq), .wakeIrq(wakeIrq));
  cswk_bus_node u_node (.clk_sys(clk_sys), .go(go), .kind(kind),
    .sendId(sendId), .len(len), .patternSeen(patternSeen),
    .frameDone(frameDone), .frameId(frameId), .frameData(frameData),
    .errOverflow(errOverflow), .silenceExpired(silenceExpired),
    .busTx(busTx));

  always #2.5 clk_sys = ~clk_sys;
  // counting pulses shows a late or doubled one
  always @(posedge clk_sys)
  begin
    cycles++;
    if (restartReq === 1'b1) nRestart++;
    if (wakeIrq === 1'b1) nIrq++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask : rdchk
  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask : pulse
  task automatic node(input logic [2:0] k, input logic [10:0] id,
    input logic [8:0] n);
    @(posedge clk_sys);
    go <= 1'b1;
    kind <= k;
    sendId <= id;
    len <= n;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask : node
  task automatic rst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
    nRestart = 0;
    nIrq = 0;
  endtask : rst

  task automatic t_restart_normal();
    for (int c = 0; c < 8; c++)
    begin
      rst();
      wr(ADDR_MODE, 8'(c));
      pulse(1);
      tick(3);
      rdchk(ADDR_MODE, (c == 2 || c == 3) ? 8'h01 : c > 5 ? 8'h05 : 8'(c));
      rdchk(ADDR_STATUS, c >= 5 ? 8'h08 : 8'h00);
    end
    $display("restart done");
  endtask : t_restart_normal
  // k 5 is a non-bus wake; config matches id 2a5
  task automatic sleep_case(input logic [2:0] code, input logic ok,
    input logic [2:0] k, input logic [10:0] id, input logic [7:0] st,
    input logic [7:0] cnt, input int nr);
    rst();
    wr(ADDR_MODE, {5'h00, code});
    for (int i = 0; i < 16; i++)
      wr(ADDR_ID0 + 5'(i), i == 0 ? 8'ha5 : i == 1 ? 8'h02 : i > 7 ? 8'h5a : 8'h00);
    rdchk(ADDR_ID0, 8'h00);
    configCheckOk <= ok;
    pulse(0);
    if (k == 3'h5) pulse(4);
    else node(k, id, 9'h000);
    tick(4);
    if (nr >= 0) chk(8'(nRestart), 8'(nr));
    rdchk(ADDR_STATUS, st);
    rdchk(ADDR_MODE, code == 3'h0 ? 8'h00 : code == 3'h1 ? 8'h01 : 8'h05);
    if (cnt != 8'hff) rdchk(ADDR_ECNT, cnt);
  endtask : sleep_case
  task automatic t_sleep();
    sleep_case(3'h0, 1'b1, 3'h5, 11'h2a5, 8'h00, 8'h00, -1);
    sleep_case(3'h1, 1'b1, 3'h5, 11'h2a5, 8'h00, 8'h00, -1);
    sleep_case(3'h1, 1'b1, 3'h0, 11'h2a5, 8'h03, 8'h00, 1);
    sleep_case(3'h5, 1'b1, 3'h1, 11'h2a5, 8'h07, 8'hff, 1);
    sleep_case(3'h5, 1'b1, 3'h1, 11'h2a4, 8'h00, 8'hff, 0);
    sleep_case(3'h7, 1'b1, 3'h2, 11'h2a5, 8'h09, 8'h20, 1);
    sleep_case(3'h5, 1'b0, 3'h0, 11'h2a5, 8'h0b, 8'h00, 1);
    $display("sleep done");
  endtask : t_sleep
  task automatic t_normal_irq();
    rst();
    wr(ADDR_MODE, 8'h01);
    node(3'h0, 11'h000, 9'h000);
    tick(4);
    chk(8'(nIrq), 8'h01);
    chk(8'(nRestart), 8'h00);
    rdchk(ADDR_STATUS, 8'h03);
    $display("irq done");
  endtask : t_normal_irq
  task automatic t_failsafe();
    rst();
    wr(ADDR_MODE, 8'h07);
    pulse(2);
    tick(4);
    rdchk(ADDR_MODE, 8'h01);
    $display("done fail-safe");
  endtask : t_failsafe
  task automatic t_decoder();
    rst();
    wr(ADDR_QUANTA, 8'ha7);
    wr(ADDR_SAMPLE, 8'h15);
    wr(ADDR_RECCLK, 8'h02);
    wr(ADDR_OSCCTL, 8'h02);
    rxMain <= 1'b0;
    tick(3);
    #1 chk(decoderQuanta, 8'ha7);
    chk(8'(decoderSample), 8'h15);
    chk(8'(decoderClkSel), 8'h02);
    chk(8'(decoderRx), 8'h01);
    wr(ADDR_OSCCTL, 8'h00);
    tick(3);
    #1 chk(8'(decoderRx), 8'h00);
    $display("decoder done");
  endtask : t_decoder
  task automatic t_osc();
    rst();
    wr(ADDR_OSCCTL, 8'h01);
    node(3'h4, 11'h000, 9'd300);
    tick(306);
    rdchk(ADDR_CNTHI, 8'h01);
    rdchk(ADDR_CNTLO, 8'h2c);
    wr(ADDR_TRIM, 8'h5a);
    wr(ADDR_OPTION, 8'h3c);
    rdchk(ADDR_TRIM, 8'h00);
    rdchk(ADDR_OPTION, 8'h00);
    wr(ADDR_OSCCTL, 8'h0d);
    wr(ADDR_TRIM, 8'h5a);
    rdchk(ADDR_TRIM, 8'h5a);
    wr(ADDR_OSCCTL, 8'h01);
    wr(ADDR_TRIM, 8'h33);
    rdchk(ADDR_TRIM, 8'h5a);
    rdchk(5'h0f, 8'h00);
    $display("osc done");
  endtask : t_osc

  initial
  begin
    t_restart_normal();
    t_sleep();
    t_normal_irq();
    t_failsafe();
    t_decoder();
    t_osc();
    finish_test();
  end
endmodule : testbench
